// File: verilog/dscw_core.sv
`timescale 1ns/1ps
`include "dscw_map.svh"

// Contract
// - Command word written only from serial network.
// - Command bits act only under serial control; bits 4 and 5 instead follow their own source selections.
// - Bit 0 runs or ramps motor down.
// - Bit 1 enables or disables the drive.
// - Bit 2 follows or opposes reference direction.
// - Bit 3 enables the inching function.
// - Bit 4 selects local or remote place.
// - Bit 5 selects first or second ramps.
// - Bit 6 high executes a quick stop.
// - Quick stop barred under scalar control types.
// - Bit 7 resets a faulted drive.
// - Bit 13 sets main controller manual mode.
// - Bit 14 sets external controller manual mode.
// - Bits 0 to 7 are objects 16 onward.
// - Reference used only when serial source chosen.
// - Signed reference, 8192 equals synchronous speed.
// - Reference above 8192 is not clamped.
// - Forward when bit 2 agrees with sign.
// - Reference is also analog object 17.

module dscw_core (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire dscw_pkg::dscw_src_t acc_src,
   input wire dscw_pkg::dscw_kind_t acc_kind,
   input wire logic [15:0] acc_index,
   input wire logic [15:0] acc_wdata,
   output logic acc_ack,
   output logic acc_err,
   output logic [15:0] acc_rdata,
   input wire logic [3:0] command_source_select,
   input wire logic [3:0] ramp_set_source_select,
   input wire logic [3:0] local_speed_ref_source,
   input wire logic [3:0] remote_speed_ref_source,
   input wire logic local_cmds_serial,
   input wire logic remote_cmds_serial,
   input wire logic drive_remote,
   input wire logic [2:0] motor_control_type,
   input wire logic fault_active,
   input wire logic [15:0] sync_rpm,
   output logic [15:0] serial_command_word,
   output logic [15:0] serial_speed_reference,
   output logic run_req,
   output logic drive_enable,
   output logic inch_run,
   output logic remote_sel,
   output logic second_ramp,
   output logic quick_stop,
   output logic fault_reset,
   output logic main_pid_manual,
   output logic ext_pid_manual,
   output logic ref_in_use,
   output logic dir_forward,
   output logic [17:0] speed_rpm
);

   import dscw_pkg::*;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   dscw_state_t state;
   dscw_state_t next_state;

   logic from_net;
   logic hit_par_cmd;
   logic hit_par_ref;
   logic hit_bv_low;
   logic hit_bv_mpid;
   logic hit_bv_epid;
   logic hit_bv;
   logic hit_anv;
   logic hit_cmd;
   logic hit_ref;
   logic hit_any;
   logic [3:0] bv_pos;
   logic wr_ok;
   logic wr_par_cmd;
   logic wr_bv;
   logic wr_ref;
   logic [15:0] next_cmd;
   logic [15:0] next_ref;
   logic [15:0] rd_value;
   logic [15:0] next_rdata;

   assign from_net = (acc_src == dscw_src_net);
   assign hit_par_cmd = (acc_kind == dscw_kind_param) && (acc_index == `DSCW_PAR_CMD);
   assign hit_par_ref = (acc_kind == dscw_kind_param) && (acc_index == `DSCW_PAR_REF);
   assign hit_bv_low = (acc_kind == dscw_kind_bin) && (acc_index >= `DSCW_BV_FIRST) &&
      (acc_index <= `DSCW_BV_LAST);
   assign hit_bv_mpid = (acc_kind == dscw_kind_bin) && (acc_index == `DSCW_BV_MPID);
   assign hit_bv_epid = (acc_kind == dscw_kind_bin) && (acc_index == `DSCW_BV_EPID);
   assign hit_bv = hit_bv_low | hit_bv_mpid | hit_bv_epid;
   assign hit_anv = (acc_kind == dscw_kind_analog) && (acc_index == `DSCW_ANV_REF);
   assign hit_cmd = hit_par_cmd | hit_bv;
   assign hit_ref = hit_par_ref | hit_anv;
   assign hit_any = hit_cmd | hit_ref;

   // Object 16 is bit 0, so the low three index bits give the position.
   assign bv_pos = hit_bv_mpid ? `DSCW_B_MPID :
      hit_bv_epid ? `DSCW_B_EPID :
      {1'b0, acc_index[2:0]};

   // Keypad and other sources see both words as read-only.
   assign wr_ok = acc_req & acc_write & from_net & hit_any;
   assign wr_par_cmd = wr_ok & hit_par_cmd;
   assign wr_bv = wr_ok & hit_bv;
   assign wr_ref = wr_ok & hit_ref;

   // ----------------------------------------
   // Command word next value
   // ----------------------------------------
   // Reserved bits are stored as written so that a read returns them, but
   // nothing downstream looks at them.
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmd_bit
         assign next_cmd[gi] = wr_par_cmd ? acc_wdata[gi] :
            (wr_bv && (bv_pos == 4'(gi))) ? acc_wdata[0] :
            serial_command_word[gi];
      end
   endgenerate

   assign next_ref = wr_ref ? acc_wdata : serial_speed_reference;

   // ----------------------------------------
   // Read path and answer
   // ----------------------------------------
   assign rd_value = hit_par_cmd ? serial_command_word :
      hit_bv ? {15'h0000, serial_command_word[bv_pos]} :
      hit_ref ? serial_speed_reference :
      `DSCW_RD_NONE;

   always_comb begin
      next_state = dscw_st_idle;
      if (acc_req) begin
         if (!hit_any) begin
            next_state = dscw_st_error;
         end else if (acc_write && !from_net) begin
            next_state = dscw_st_error;
         end else if (acc_write) begin
            next_state = dscw_st_write;
         end else begin
            next_state = dscw_st_read;
         end
      end
   end

   assign next_rdata = (acc_req && !acc_write && hit_any) ? rd_value : `DSCW_RD_NONE;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= dscw_st_idle;
         acc_rdata <= `DSCW_RD_NONE;
      end else begin
         state <= next_state;
         acc_rdata <= next_rdata;
      end
   end

   always_comb begin
      acc_ack = 1'b0;
      acc_err = 1'b0;
      case (state)
         dscw_st_idle: begin
            acc_ack = 1'b0;
         end
         dscw_st_write: begin
            acc_ack = 1'b1;
         end
         dscw_st_read: begin
            acc_ack = 1'b1;
         end
         dscw_st_error: begin
            acc_ack = 1'b1;
            acc_err = 1'b1;
         end
         default: begin
            acc_ack = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Stored words
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_command_word <= `DSCW_CMD_RST;
         serial_speed_reference <= `DSCW_REF_RST;
      end else begin
         serial_command_word <= next_cmd;
         serial_speed_reference <= next_ref;
      end
   end

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic dec_remote;
   logic dec_active;
   logic dec_run;
   logic dec_enable;
   logic dec_inch;
   logic dec_ramp;
   logic dec_qstop;
   logic dec_frst;
   logic dec_mpid;
   logic dec_epid;
   logic frst_prev;
   logic next_fault_reset;

   dscw_cmd_decode u_decode (
      .cmd_word(serial_command_word),
      .command_source_select(command_source_select),
      .ramp_set_source_select(ramp_set_source_select),
      .local_cmds_serial(local_cmds_serial),
      .remote_cmds_serial(remote_cmds_serial),
      .drive_remote(drive_remote),
      .motor_control_type(motor_control_type),
      .remote_sel(dec_remote),
      .cmd_active(dec_active),
      .run_req(dec_run),
      .drive_enable(dec_enable),
      .inch_run(dec_inch),
      .second_ramp(dec_ramp),
      .quick_stop(dec_qstop),
      .fault_reset_lvl(dec_frst),
      .main_pid_manual(dec_mpid),
      .ext_pid_manual(dec_epid)
   );

   // A held bit 7 must not keep resetting, so only its rise while faulted
   // makes a single reset pulse.
   assign next_fault_reset = dec_frst & ~frst_prev & fault_active;

   // ----------------------------------------
   // Speed reference
   // ----------------------------------------
   logic ref_serial;
   logic sc_forward;
   logic [17:0] sc_rpm;

   assign ref_serial = dec_remote ?
      (remote_speed_ref_source == `DSCW_SRC_SERIAL) :
      (local_speed_ref_source == `DSCW_SRC_SERIAL);

   dscw_ref_scale u_scale (
      .speed_ref(serial_speed_reference),
      .dir_bit(serial_command_word[`DSCW_B_DIR]),
      .sync_rpm(sync_rpm),
      .dir_forward(sc_forward),
      .speed_rpm(sc_rpm)
   );

   // ----------------------------------------
   // Registered drive requests
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_req <= 1'b0;
         drive_enable <= 1'b0;
         inch_run <= 1'b0;
         remote_sel <= 1'b0;
         second_ramp <= 1'b0;
         quick_stop <= 1'b0;
         main_pid_manual <= 1'b0;
         ext_pid_manual <= 1'b0;
      end else begin
         run_req <= dec_run;
         drive_enable <= dec_enable;
         inch_run <= dec_inch;
         remote_sel <= dec_remote;
         second_ramp <= dec_ramp;
         quick_stop <= dec_qstop;
         main_pid_manual <= dec_mpid;
         ext_pid_manual <= dec_epid;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         frst_prev <= 1'b0;
         fault_reset <= 1'b0;
      end else begin
         frst_prev <= dec_frst;
         fault_reset <= next_fault_reset;
      end
   end

   // With the reference not in use, speed and direction read as zero so the
   // drive cannot pick up a stale serial value.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_in_use <= 1'b0;
         dir_forward <= 1'b0;
         speed_rpm <= 18'h0_0000;
      end else begin
         ref_in_use <= ref_serial;
         dir_forward <= ref_serial & dec_active & sc_forward;
         speed_rpm <= ref_serial ? sc_rpm : 18'h0_0000;
      end
   end

endmodule : dscw_core

// File: verilog/dscw_map.svh
`ifndef DSCW_MAP_SVH
`define DSCW_MAP_SVH

// ----------------------------------------
// Parameter numbers and object instances
// ----------------------------------------
`define DSCW_PAR_CMD 16'h02AA
`define DSCW_PAR_REF 16'h02AB
`define DSCW_BV_FIRST 16'h0010
`define DSCW_BV_LAST 16'h0017
`define DSCW_BV_MPID 16'h001C
`define DSCW_BV_EPID 16'h001D
`define DSCW_ANV_REF 16'h0011

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSCW_CMD_RST 16'h0000
`define DSCW_REF_RST 16'h0000
`define DSCW_RD_NONE 16'h0000

// ----------------------------------------
// Command word bit positions
// ----------------------------------------
`define DSCW_B_RUN 4'h0
`define DSCW_B_ENA 4'h1
`define DSCW_B_DIR 4'h2
`define DSCW_B_INCH 4'h3
`define DSCW_B_LREM 4'h4
`define DSCW_B_RAMP 4'h5
`define DSCW_B_QSTP 4'h6
`define DSCW_B_FRST 4'h7
`define DSCW_B_MPID 4'hD
`define DSCW_B_EPID 4'hE

// ----------------------------------------
// Setting codes and scale
// ----------------------------------------
`define DSCW_SRC_SERIAL 4'h5
`define DSCW_CTRL_VF 3'h0
`define DSCW_CTRL_VVW 3'h5
`define DSCW_SCALE_SHIFT 6'hD

`endif

// File: verilog/dscw_pkg.sv
package dscw_pkg;

   typedef enum logic [1:0] {
      dscw_src_net = 2'b00,
      dscw_src_hmi = 2'b01,
      dscw_src_other = 2'b10
   } dscw_src_t;

   typedef enum logic [1:0] {
      dscw_kind_param = 2'b00,
      dscw_kind_bin = 2'b01,
      dscw_kind_analog = 2'b10
   } dscw_kind_t;

   typedef enum logic [1:0] {
      dscw_st_idle = 2'b00,
      dscw_st_write = 2'b01,
      dscw_st_read = 2'b10,
      dscw_st_error = 2'b11
   } dscw_state_t;

endpackage : dscw_pkg

// File: verilog/dscw_cmd_decode.sv
`timescale 1ns/1ps
`include "dscw_map.svh"

module dscw_cmd_decode (
   input wire logic [15:0] cmd_word,
   input wire logic [3:0] command_source_select,
   input wire logic [3:0] ramp_set_source_select,
   input wire logic local_cmds_serial,
   input wire logic remote_cmds_serial,
   input wire logic drive_remote,
   input wire logic [2:0] motor_control_type,
   output logic remote_sel,
   output logic cmd_active,
   output logic run_req,
   output logic drive_enable,
   output logic inch_run,
   output logic second_ramp,
   output logic quick_stop,
   output logic fault_reset_lvl,
   output logic main_pid_manual,
   output logic ext_pid_manual
);

   logic lrem_serial;
   logic scalar_type;

   // Place comes from the word only when the serial link owns the selection.
   assign lrem_serial = (command_source_select == `DSCW_SRC_SERIAL);
   assign remote_sel = lrem_serial ? cmd_word[`DSCW_B_LREM] : drive_remote;
   assign cmd_active = remote_sel ? remote_cmds_serial : local_cmds_serial;
   assign scalar_type = (motor_control_type == `DSCW_CTRL_VF) ||
      (motor_control_type == `DSCW_CTRL_VVW);

   assign run_req = cmd_active & cmd_word[`DSCW_B_RUN];
   assign drive_enable = cmd_active & cmd_word[`DSCW_B_ENA];
   assign inch_run = cmd_active & cmd_word[`DSCW_B_INCH];
   assign second_ramp = (ramp_set_source_select == `DSCW_SRC_SERIAL) &
      cmd_word[`DSCW_B_RAMP];
   assign quick_stop = cmd_active & ~scalar_type & cmd_word[`DSCW_B_QSTP];
   assign fault_reset_lvl = cmd_active & cmd_word[`DSCW_B_FRST];
   assign main_pid_manual = cmd_active & cmd_word[`DSCW_B_MPID];
   assign ext_pid_manual = cmd_active & cmd_word[`DSCW_B_EPID];

endmodule : dscw_cmd_decode

// File: verilog/dscw_ref_scale.sv
`timescale 1ns/1ps
`include "dscw_map.svh"

module dscw_ref_scale (
   input wire logic [15:0] speed_ref,
   input wire logic dir_bit,
   input wire logic [15:0] sync_rpm,
   output logic dir_forward,
   output logic [17:0] speed_rpm
);

   logic ref_neg;
   logic ref_pos;
   logic [15:0] ref_mag;
   logic [31:0] product;

   assign ref_neg = speed_ref[15];
   assign ref_pos = ~ref_neg & (speed_ref != `DSCW_REF_RST);
   // Zero speed gives reverse, since neither forward case applies.
   assign dir_forward = dir_bit ? ref_pos : ref_neg;
   assign ref_mag = ref_neg ? 16'(~speed_ref + 16'h0001) : speed_ref;
   // The magnitude of the most negative code is 8000h, read as unsigned.
   assign product = 32'(ref_mag) * 32'(sync_rpm);
   // No clamp: codes above 2000h scale past synchronous speed.
   assign speed_rpm = 18'(product >> `DSCW_SCALE_SHIFT);

endmodule : dscw_ref_scale

// File: sim/dscw_net_master.sv
`timescale 1ns/1ps
module dscw_net_master (
   input wire logic ref_clk,
   output logic acc_req,
   output logic acc_write,
   output dscw_pkg::dscw_src_t acc_src,
   output dscw_pkg::dscw_kind_t acc_kind,
   output logic [15:0] acc_index,
   output logic [15:0] acc_wdata,
   input wire logic acc_ack,
   input wire logic acc_err,
   input wire logic [15:0] acc_rdata
);
   import dscw_pkg::*;
   initial begin
      acc_req = 1'b0;
      acc_write = 1'b0;
      acc_src = dscw_src_net;
      acc_kind = dscw_kind_param;
      acc_index = 16'h0000;
      acc_wdata = 16'h0000;
   end
   // Index and data lines are inverted on release, so a late reader sees junk, not the old value.
   task automatic xfer(input logic wr, input dscw_src_t s, input dscw_kind_t k,
         input logic [15:0] i, input logic [15:0] d,
         output logic [15:0] rd, output logic er, output logic ok);
      ok = 1'b0;
      rd = 16'h0000;
      er = 1'b0;
      @(posedge ref_clk);
      acc_req <= 1'b1;
      acc_write <= wr;
      acc_src <= s;
      acc_kind <= k;
      acc_index <= i;
      acc_wdata <= d;
      @(posedge ref_clk);
      acc_req <= 1'b0;
      acc_index <= ~i;
      acc_wdata <= ~d;
      for (int n = 0; n < 4; n++) begin
         #1;
         if (acc_ack === 1'b1) begin
            ok = 1'b1;
            rd = acc_rdata;
            er = acc_err;
            break;
         end
         @(posedge ref_clk);
      end
   endtask : xfer
endmodule : dscw_net_master

// File: sim/dscw_core_sva.sv
`timescale 1ns/1ps
`include "dscw_map.svh"
module dscw_core_sva (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire dscw_pkg::dscw_src_t acc_src,
   input wire dscw_pkg::dscw_kind_t acc_kind,
   input wire logic [15:0] acc_index,
   input wire logic [15:0] acc_wdata,
   input wire logic acc_ack,
   input wire logic acc_err,
   input wire logic [3:0] ramp_set_source_select,
   input wire logic [3:0] local_speed_ref_source,
   input wire logic [3:0] remote_speed_ref_source,
   input wire logic local_cmds_serial,
   input wire logic remote_cmds_serial,
   input wire logic [2:0] motor_control_type,
   input wire logic [15:0] serial_command_word,
   input wire logic run_req,
   input wire logic drive_enable,
   input wire logic second_ramp,
   input wire logic quick_stop,
   input wire logic fault_reset,
   input wire logic ref_in_use,
   input wire logic [17:0] speed_rpm
);
   import dscw_pkg::*;
   wire logic cmd_wr = acc_req && acc_write && acc_kind == dscw_kind_param &&
      acc_index == `DSCW_PAR_CMD;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   a_ack_one_cycle:
      assert property (acc_req |=> acc_ack) else $error("ack missing");
   a_ack_has_cause:
      assert property (acc_ack |-> $past(acc_req)) else $error("stray ack");
   a_foreign_refused:
      assert property (cmd_wr && acc_src != dscw_src_net |=> acc_err &&
         serial_command_word == $past(serial_command_word)) else $error("foreign write");
   a_net_stores:
      assert property (cmd_wr && acc_src == dscw_src_net |=>
         serial_command_word == $past(acc_wdata)) else $error("write lost");
   a_inactive_quiet:
      assert property (!local_cmds_serial && !remote_cmds_serial |=>
         !run_req && !drive_enable) else $error("inactive command acted");
   a_ramp_gated:
      assert property (ramp_set_source_select != `DSCW_SRC_SERIAL |=> !second_ramp)
         else $error("ramp not gated");
   a_qstop_scalar:
      assert property (motor_control_type inside {`DSCW_CTRL_VF, `DSCW_CTRL_VVW}
         |=> !quick_stop) else $error("quick stop under scalar");
   a_reset_pulse:
      assert property (fault_reset |=> !fault_reset) else $error("fault reset held");
   a_ref_unused:
      assert property (local_speed_ref_source != `DSCW_SRC_SERIAL &&
         remote_speed_ref_source != `DSCW_SRC_SERIAL |=> !ref_in_use &&
         speed_rpm == 18'h0_0000) else $error("reference used");
endmodule : dscw_core_sva
bind dscw_core dscw_core_sva u_dscw_core_sva (.*);

// File: sim/drive_serial_command_word_tb_top.sv
`timescale 1ns/1ps
`include "dscw_map.svh"
module drive_serial_command_word_tb_top;
   import dscw_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic acc_req, acc_write, acc_ack, acc_err, er;
   dscw_src_t acc_src;
   dscw_kind_t acc_kind;
   logic [15:0] acc_index, acc_wdata, acc_rdata, rd, w;
   logic [3:0] command_source_select = 4'h5;
   logic [3:0] ramp_set_source_select = 4'h5;
   logic [3:0] local_speed_ref_source = 4'h5;
   logic [3:0] remote_speed_ref_source = 4'h5;
   logic local_cmds_serial = 1'b1;
   logic remote_cmds_serial = 1'b1;
   logic drive_remote = 1'b0;
   logic [2:0] motor_control_type = 3'h1;
   logic fault_active = 1'b1;
   logic [15:0] sync_rpm = 16'h0708;
   logic [15:0] serial_command_word, serial_speed_reference;
   logic run_req, drive_enable, inch_run, remote_sel, second_ramp, quick_stop;
   logic fault_reset, main_pid_manual, ext_pid_manual, ref_in_use, dir_forward;
   logic [17:0] speed_rpm;
   int n_errors = 0;
   int num_checks = 0;
   int cnt;
   logic [15:0] rv [4] = '{16'h1000, 16'hE000, 16'hE000, 16'h4000};
   logic [17:0] rp [4] = '{18'h0_0384, 18'h0_0708, 18'h0_0708, 18'h0_0E10};
   logic [3:0] bt = 4'h3;
   logic [3:0] df = 4'h5;
   wire logic [7:0] ov = {run_req, drive_enable, inch_run, remote_sel, second_ramp,
      quick_stop, main_pid_manual, ext_pid_manual};
   always #12.5 ref_clk = ~ref_clk;
   dscw_core u_dscw_core (.*);
   dscw_net_master u_dscw_net_master (.*);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic final_report();
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic acc(input logic wr, input dscw_src_t s, input dscw_kind_t k,
         input logic [15:0] i, input logic [15:0] d);
      logic ok;
      u_dscw_net_master.xfer(wr, s, k, i, d, rd, er, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         final_report();
      end
   endtask : acc
   task automatic wrn(input dscw_kind_t k, input logic [15:0] i, input logic [15:0] d);
      acc(1'b1, dscw_src_net, k, i, d);
      chk("write_err", 32'h0000_0000, er);
   endtask : wrn
   task automatic rdc(input string nm, input dscw_src_t s, input dscw_kind_t k,
         input logic [15:0] i, input logic [16:0] e);
      acc(1'b0, s, k, i, 16'h0000);
      chk(nm, e, {er, rd});
   endtask : rdc
   // Decoded outputs trail the stored word and the settings by one edge.
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : settle
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("reset", 32'h0000_0000, {serial_command_word, serial_speed_reference});
      for (int b = 0; b < 16; b++) begin
         w = 16'h0001 << b;
         wrn(dscw_kind_param, `DSCW_PAR_CMD, w);
         settle();
         chk("outs", {w[0], w[1], w[3], w[4], w[5], w[6], w[13], w[14]}, ov);
         rdc("cmd", dscw_src_hmi, dscw_kind_param, `DSCW_PAR_CMD, {1'b0, w});
      end
      acc(1'b1, dscw_src_hmi, dscw_kind_param, `DSCW_PAR_CMD, 16'h0003);
      chk("foreign", 32'h0000_0001, er);
      rdc("kept", dscw_src_other, dscw_kind_param, `DSCW_PAR_CMD, 17'h0_8000);
      wrn(dscw_kind_param, `DSCW_PAR_CMD, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wrn(dscw_kind_bin, 16'(`DSCW_BV_FIRST + i), 16'h0001);
         rdc("bin", dscw_src_net, dscw_kind_param, `DSCW_PAR_CMD,
            17'((17'h0_0002 << i) - 17'h0_0001));
      end
      wrn(dscw_kind_bin, `DSCW_BV_MPID, 16'h0001);
      wrn(dscw_kind_bin, `DSCW_BV_EPID, 16'h0001);
      rdc("pid", dscw_src_net, dscw_kind_param, `DSCW_PAR_CMD, 17'h0_60FF);
      rdc("bin_rd", dscw_src_hmi, dscw_kind_bin, 16'h0012, 17'h0_0001);
      acc(1'b1, dscw_src_net, dscw_kind_bin, 16'h0018, 16'h0001);
      chk("unmapped", 32'h0000_0001, er);
      @(posedge ref_clk);
      local_cmds_serial <= 1'b0;
      remote_cmds_serial <= 1'b0;
      settle();
      // Place and ramp set follow their own source selections, not the command gate.
      chk("inactive", 32'h0000_0018, ov);
      @(posedge ref_clk);
      local_cmds_serial <= 1'b1;
      remote_cmds_serial <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         @(posedge ref_clk);
         motor_control_type <= (m == 0) ? `DSCW_CTRL_VF : (m == 1) ? `DSCW_CTRL_VVW : 3'h2;
         ramp_set_source_select <= (m == 2) ? 4'h5 : 4'h4;
         settle();
         chk("qs_ramp", {2{m == 2}}, {quick_stop, second_ramp});
      end
      wrn(dscw_kind_param, `DSCW_PAR_CMD, 16'h0003);
      settle();
      wrn(dscw_kind_param, `DSCW_PAR_CMD, 16'h0083);
      cnt = 0;
      repeat (4) begin
         @(posedge ref_clk);
         #1;
         if (fault_reset === 1'b1)
            cnt++;
      end
      chk("pulses", 32'h0000_0001, cnt);
      for (int j = 0; j < 4; j++) begin
         wrn(dscw_kind_param, `DSCW_PAR_CMD, {13'h0000, bt[j], 2'h3});
         wrn(dscw_kind_analog, `DSCW_ANV_REF, rv[j]);
         settle();
         chk("speed", {1'b1, df[j], rp[j]}, {ref_in_use, dir_forward, speed_rpm});
         rdc("ref", dscw_src_hmi, dscw_kind_param, `DSCW_PAR_REF, {1'b0, rv[j]});
      end
      acc(1'b1, dscw_src_hmi, dscw_kind_param, `DSCW_PAR_REF, 16'h0100);
      chk("ref_foreign", 32'h0001_4000, {er, serial_speed_reference});
      @(posedge ref_clk);
      local_speed_ref_source <= 4'h4;
      remote_speed_ref_source <= 4'h4;
      settle();
      chk("ref_unused", 32'h0000_0000, {ref_in_use, speed_rpm});
      @(posedge ref_clk);
      command_source_select <= 4'h4;
      drive_remote <= 1'b1;
      settle();
      chk("place_pin", 32'h0000_0001, remote_sel);
      final_report();
   end
endmodule : drive_serial_command_word_tb_top
